// ### verilog/uc_pkg.sv
// Purpose: shared constants and types for the serial channel in uart personality
// Assumes: ahb-lite register access, one word per register, byte address = 4 * index
// Notes: register indexes are kept as printed; only the first channel's set is decoded
`default_nettype none
package uc_pkg;
  // register indexes (byte address is four times the index)
  localparam logic [7:0] UC_IDX_P1_CTRL = 8'h95;
  localparam logic [7:0] UC_IDX_P1_BAUD_LO = 8'h9d;
  localparam logic [7:0] UC_IDX_P1_BAUD_HI = 8'h9e;
  localparam logic [7:0] UC_IDX_P1_DATA = 8'h9f;
  localparam logic [7:0] UC_IDX_P2_CTRL = 8'ha4;
  localparam logic [7:0] UC_IDX_P2_BAUD_LO = 8'ha5;
  localparam logic [7:0] UC_IDX_P2_BAUD_HI = 8'ha6;
  localparam logic [7:0] UC_IDX_P2_DATA = 8'ha7;
  localparam logic [7:0] UC_IDX_PX_CTRL = 8'hc4;
  localparam logic [7:0] UC_IDX_PX_BAUD_LO = 8'hc5;
  localparam logic [7:0] UC_IDX_PX_BAUD_HI = 8'hc6;
  localparam logic [7:0] UC_IDX_PX_DATA = 8'hc7;
  // function select and interrupt mask registers
  localparam logic [7:0] UC_IDX_FSEL = 8'hf0;
  localparam logic [7:0] UC_IDX_IRQ_MASK = 8'hf1;

  // control register field positions
  localparam int unsigned UC_BIT_MODE_HI = 7;
  localparam int unsigned UC_BIT_MODE_LO = 6;
  localparam int unsigned UC_BIT_MPR = 5;
  localparam int unsigned UC_BIT_REN = 4;
  localparam int unsigned UC_BIT_TX9 = 3;
  localparam int unsigned UC_BIT_RX9 = 2;
  localparam int unsigned UC_BIT_TI = 1;
  localparam int unsigned UC_BIT_RI = 0;

  // values after reset
  localparam logic [7:0] UC_RST_BYTE = 8'h00;
  localparam logic [1:0] UC_RST_FSEL = 2'b00;
  localparam logic [1:0] UC_RST_MASK = 2'b00;

  // function select value for the uart personality
  localparam logic [1:0] UC_FSEL_UART = 2'b11;
  // ahb encodings
  localparam logic [2:0] UC_HSIZE_WORD = 3'b010;
  // shift clock periods of the synchronous mode, in system clocks
  localparam logic [3:0] UC_SYNC_PER_SLOW = 4'hc;
  localparam logic [3:0] UC_SYNC_PER_FAST = 4'h4;
  localparam logic [2:0] UC_LAST_BIT = 3'h7;

  // serial modes
  typedef enum logic [1:0] {
    UC_MODE_SYNC = 2'b00,
    UC_MODE_ASYNC10 = 2'b01,
    UC_MODE_RSVD = 2'b10,
    UC_MODE_ASYNC11 = 2'b11
  } uc_mode_e;

  // captured ahb address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic hit;
    logic [7:0] idx;
  } uc_ahb_req_s;

  // serial pins driven by the channel
  typedef struct packed {
    logic tx_pin;
    logic rx_pin_out;
    logic rx_pin_oe;
  } uc_link_s;
endpackage
`default_nettype wire

// ### verilog/uc_uart.sv
// Purpose: one serial channel in uart personality with an ahb-lite register slave
// Assumes: single clock hclk, pins synchronous to it, async active-low reset
// Notes: every transfer takes one wait state; read data and all outputs are flopped
// What this block does
// R1: uart active when function select equals 11
// R2: set done flags after frame sent or received
// R3: done flags cleared only by writing one
// R4: mode 00 is 8-bit synchronous half duplex
// R5: synchronous frames shift least significant bit first
// R6: mode 01 is ten-bit asynchronous frame
// R7: mode 11 eleven-bit frame, mode 10 reserved
// R8: multiprocessor bit filters frames by ninth bit
// R9: rate bit picks sync clock twelfth or quarter
// R10: receive only while receive permit is set
// R11: ninth transmit bit sent in eleven-bit mode
// R12: received ninth bit stored in eleven-bit mode
// R13: baud rate is clock over 16-bit divisor
// R14: software keeps divisor above hexadecimal 10
// R15: data buffer write starts a transmission
// R16: data buffer read returns receive latch
// R17: start edge, centre sampling, high stop, idle high
// R18: flags set at end of stop bit
`default_nettype none
module uc_uart
  import uc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic rx_pin_in,
  output uc_link_s link,
  output logic irq
);

  // decode of a word index that this channel answers
  function automatic logic uc_mapped(input logic [7:0] idx);
    uc_mapped = (idx == UC_IDX_P1_CTRL) || (idx == UC_IDX_P1_BAUD_LO) ||
                (idx == UC_IDX_P1_BAUD_HI) || (idx == UC_IDX_P1_DATA) ||
                (idx == UC_IDX_FSEL) || (idx == UC_IDX_IRQ_MASK);
  endfunction

  typedef enum logic [2:0] {
    UC_TX_IDLE = 3'b000,
    UC_TX_START = 3'b001,
    UC_TX_DATA = 3'b010,
    UC_TX_NINTH = 3'b011,
    UC_TX_STOP = 3'b100
  } uc_tx_e;

  typedef enum logic [2:0] {
    UC_RX_IDLE = 3'b000,
    UC_RX_START = 3'b001,
    UC_RX_DATA = 3'b010,
    UC_RX_NINTH = 3'b011,
    UC_RX_STOP = 3'b100,
    UC_RX_END = 3'b101
  } uc_rx_e;

  typedef enum logic [1:0] {
    UC_SY_IDLE = 2'b00,
    UC_SY_TX = 2'b01,
    UC_SY_RX = 2'b10
  } uc_sy_e;

  // software visible state
  logic [1:0] fsel; // function select
  uc_mode_e mode; // serial mode
  logic mpr; // multiprocessor or rate bit
  logic ren; // receive permit
  logic tx9; // ninth bit to send
  logic rx9; // ninth bit received
  logic ti; // transmit done flag
  logic ri; // receive done flag
  logic [7:0] baud_lo; // divisor low byte
  logic [7:0] baud_hi; // divisor high byte
  logic [7:0] rx_latch; // receive latch
  logic [1:0] irq_mask; // mask, same layout as flags

  // bus state
  uc_ahb_req_s req; // held address phase

  // engines
  uc_tx_e tx_st;
  logic [15:0] tx_cnt;
  logic [2:0] tx_n;
  logic [7:0] tx_sh;
  logic tx_line;
  logic tx_long;
  uc_rx_e rx_st;
  logic [15:0] rx_cnt;
  logic [2:0] rx_n;
  logic [7:0] rx_sh;
  logic rx_b9;
  logic rx_long;
  logic rx_prev;
  uc_sy_e sy_st;
  logic [3:0] sy_cnt;
  logic [2:0] sy_n;
  logic [7:0] sy_sh;
  logic sy_out;

  // combinational helpers
  logic uart_on;
  logic async_mode;
  logic [15:0] div;
  logic [15:0] div_last;
  logic [15:0] half_last;
  logic [3:0] sy_per;
  logic [3:0] sy_half;
  logic bus_wr;
  logic bus_rd;
  logic wr_ctrl;
  logic wr_data;
  logic tx_go;
  logic atx_tick;
  logic atx_fin;
  logic arx_tick;
  logic arx_half;
  logic arx_keep;
  logic arx_fin;
  logic sy_tick;
  logic sy_tx_fin;
  logic sy_rx_fin;
  logic sy_clk;

  assign uart_on = (fsel == UC_FSEL_UART); // R1
  assign async_mode = (mode == UC_MODE_ASYNC10) || (mode == UC_MODE_ASYNC11); // R6 R7
  assign div = {baud_hi, baud_lo}; // R13
  assign div_last = div - 16'h0001;
  assign half_last = (div >> 1) - 16'h0001; // R17
  assign sy_per = mpr ? UC_SYNC_PER_FAST : UC_SYNC_PER_SLOW; // R9
  assign sy_half = sy_per >> 1;
  assign bus_wr = req.valid && req.write && req.hit;
  assign bus_rd = req.valid && !req.write;
  assign wr_ctrl = bus_wr && (req.idx == UC_IDX_P1_CTRL);
  assign wr_data = bus_wr && (req.idx == UC_IDX_P1_DATA);
  // new frame only when neither the transmitter nor the shift engine is busy
  assign tx_go = wr_data && uart_on && (tx_st == UC_TX_IDLE) && (sy_st == UC_SY_IDLE); // R15
  assign atx_tick = (tx_cnt == div_last);
  assign atx_fin = (tx_st == UC_TX_STOP) && atx_tick; // R18
  assign arx_tick = (rx_cnt == div_last);
  assign arx_half = (rx_cnt == half_last);
  assign arx_keep = !(rx_long && mpr && !rx_b9); // R8
  assign arx_fin = (rx_st == UC_RX_END) && arx_half && arx_keep; // R18
  assign sy_tick = (sy_cnt == sy_per - 4'h1);
  assign sy_tx_fin = (sy_st == UC_SY_TX) && sy_tick && (sy_n == UC_LAST_BIT);
  assign sy_rx_fin = (sy_st == UC_SY_RX) && sy_tick && (sy_n == UC_LAST_BIT);
  // shift clock low in first half of each bit, high while idle
  assign sy_clk = !((sy_st != UC_SY_IDLE) && (sy_cnt < sy_half)); // R4

  // ahb address phase capture, one wait state per transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= '0;
      hreadyout <= 1'b1;
    end else if (req.valid) begin
      // data phase completes here
      req.valid <= 1'b0;
      hreadyout <= 1'b1;
    end else if (hsel && htrans[1] && hready) begin
      req.valid <= 1'b1;
      req.write <= hwrite;
      req.idx <= haddr[9:2];
      req.hit <= (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00) &&
                 (hsize == UC_HSIZE_WORD) && uc_mapped(haddr[9:2]);
      hreadyout <= 1'b0;
    end
  end

  // read data mux, unmapped reads give zero, response always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else if (bus_rd) begin
      // refused accesses (unaligned, non-word, out of range) read as zero
      case (req.hit ? req.idx : 8'h00)
        UC_IDX_P1_CTRL: hrdata <= {24'h00_0000, mode, mpr, ren, tx9, rx9, ti, ri};
        UC_IDX_P1_BAUD_LO: hrdata <= {24'h00_0000, baud_lo};
        UC_IDX_P1_BAUD_HI: hrdata <= {24'h00_0000, baud_hi};
        UC_IDX_P1_DATA: hrdata <= {24'h00_0000, rx_latch}; // R16
        UC_IDX_FSEL: hrdata <= {30'h0000_0000, fsel};
        UC_IDX_IRQ_MASK: hrdata <= {30'h0000_0000, irq_mask};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // plain configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fsel <= UC_RST_FSEL;
      mode <= UC_MODE_SYNC;
      mpr <= 1'b0;
      ren <= 1'b0;
      tx9 <= 1'b0;
      baud_lo <= UC_RST_BYTE;
      baud_hi <= UC_RST_BYTE;
      irq_mask <= UC_RST_MASK;
    end else if (bus_wr) begin
      case (req.idx)
        UC_IDX_P1_CTRL: begin
          mode <= uc_mode_e'(hwdata[UC_BIT_MODE_HI:UC_BIT_MODE_LO]);
          mpr <= hwdata[UC_BIT_MPR];
          ren <= hwdata[UC_BIT_REN];
          tx9 <= hwdata[UC_BIT_TX9];
        end
        UC_IDX_P1_BAUD_LO: baud_lo <= hwdata[7:0];
        UC_IDX_P1_BAUD_HI: baud_hi <= hwdata[7:0];
        UC_IDX_FSEL: fsel <= hwdata[1:0];
        UC_IDX_IRQ_MASK: irq_mask <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // done flags: hardware set wins over a write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ti <= 1'b0;
      ri <= 1'b0;
    end else begin
      ti <= (ti && !(wr_ctrl && hwdata[UC_BIT_TI])) || atx_fin || sy_tx_fin; // R2 R3
      ri <= (ri && !(wr_ctrl && hwdata[UC_BIT_RI])) || arx_fin || sy_rx_fin; // R2 R3
    end
  end

  // receive latch and received ninth bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_latch <= UC_RST_BYTE;
      rx9 <= 1'b0;
    end else if (arx_fin) begin
      rx_latch <= rx_sh; // R18
      if (rx_long) begin
        rx9 <= rx_b9; // R12
      end
    end else if (sy_rx_fin) begin
      rx_latch <= sy_sh;
    end else if (wr_ctrl) begin
      rx9 <= hwdata[UC_BIT_RX9];
    end
  end

  // asynchronous transmitter, one bit per divisor period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st <= UC_TX_IDLE;
      tx_cnt <= 16'h0000;
      tx_n <= 3'h0;
      tx_sh <= UC_RST_BYTE;
      tx_line <= 1'b1;
      tx_long <= 1'b0;
    end else if (!uart_on) begin
      tx_st <= UC_TX_IDLE;
      tx_line <= 1'b1;
    end else begin
      case (tx_st)
        UC_TX_IDLE: begin
          tx_line <= 1'b1; // R17
          if (tx_go && async_mode) begin
            tx_sh <= hwdata[7:0]; // R15
            tx_long <= (mode == UC_MODE_ASYNC11);
            tx_cnt <= 16'h0000;
            tx_n <= 3'h0;
            tx_line <= 1'b0; // R6
            tx_st <= UC_TX_START;
          end
        end
        default: begin
          if (!atx_tick) begin
            tx_cnt <= tx_cnt + 16'h0001;
          end else begin
            tx_cnt <= 16'h0000;
            case (tx_st)
              UC_TX_START: begin
                tx_line <= tx_sh[0];
                tx_st <= UC_TX_DATA;
              end
              UC_TX_DATA: begin
                tx_sh <= tx_sh >> 1;
                tx_n <= tx_n + 3'h1;
                if (tx_n != UC_LAST_BIT) begin
                  tx_line <= tx_sh[1];
                end else if (tx_long) begin
                  tx_line <= tx9; // R11
                  tx_st <= UC_TX_NINTH;
                end else begin
                  tx_line <= 1'b1;
                  tx_st <= UC_TX_STOP;
                end
              end
              UC_TX_NINTH: begin
                tx_line <= 1'b1; // R7
                tx_st <= UC_TX_STOP;
              end
              default: begin
                tx_line <= 1'b1;
                tx_st <= UC_TX_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // asynchronous receiver, centre sampling from the start edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st <= UC_RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_n <= 3'h0;
      rx_sh <= UC_RST_BYTE;
      rx_b9 <= 1'b0;
      rx_long <= 1'b0;
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= rx_pin_in;
      rx_cnt <= rx_cnt + 16'h0001;
      case (rx_st)
        UC_RX_IDLE: begin
          // falling edge opens a frame while permitted
          if (uart_on && async_mode && ren && rx_prev && !rx_pin_in) begin // R10 R17
            rx_long <= (mode == UC_MODE_ASYNC11);
            rx_cnt <= 16'h0000;
            rx_n <= 3'h0;
            rx_st <= UC_RX_START;
          end
        end
        UC_RX_START: begin
          if (arx_half) begin
            rx_cnt <= 16'h0000;
            // a start bit gone high at its centre was a glitch
            rx_st <= rx_pin_in ? UC_RX_IDLE : UC_RX_DATA; // R17
          end
        end
        UC_RX_DATA: begin
          if (arx_tick) begin
            rx_cnt <= 16'h0000;
            rx_sh <= {rx_pin_in, rx_sh[7:1]};
            rx_n <= rx_n + 3'h1;
            if (rx_n == UC_LAST_BIT) begin
              rx_st <= rx_long ? UC_RX_NINTH : UC_RX_STOP;
            end
          end
        end
        UC_RX_NINTH: begin
          if (arx_tick) begin
            rx_cnt <= 16'h0000;
            rx_b9 <= rx_pin_in;
            rx_st <= UC_RX_STOP;
          end
        end
        UC_RX_STOP: begin
          if (arx_tick) begin
            rx_cnt <= 16'h0000;
            // low stop bit drops the frame
            rx_st <= rx_pin_in ? UC_RX_END : UC_RX_IDLE; // R17
          end
        end
        UC_RX_END: begin
          // second half of stop bit, then publish
          if (arx_half) begin
            rx_st <= UC_RX_IDLE; // R18
          end
        end
        default: rx_st <= UC_RX_IDLE;
      endcase
    end
  end

  // synchronous shift engine, data on rx pin, clock on tx pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sy_st <= UC_SY_IDLE;
      sy_cnt <= 4'h0;
      sy_n <= 3'h0;
      sy_sh <= UC_RST_BYTE;
      sy_out <= 1'b1;
    end else if (!uart_on || (mode != UC_MODE_SYNC)) begin
      sy_st <= UC_SY_IDLE;
    end else begin
      sy_cnt <= sy_tick ? 4'h0 : sy_cnt + 4'h1;
      case (sy_st)
        UC_SY_IDLE: begin
          sy_cnt <= 4'h0;
          sy_n <= 3'h0;
          if (tx_go) begin
            sy_sh <= hwdata[7:0]; // R4 R15
            sy_out <= hwdata[0]; // R5
            sy_st <= UC_SY_TX;
          end else if (ren && !ri) begin
            sy_st <= UC_SY_RX; // R10
          end
        end
        UC_SY_TX: begin
          if (sy_tick) begin
            sy_n <= sy_n + 3'h1;
            sy_sh <= sy_sh >> 1;
            sy_out <= sy_sh[1]; // R5
            if (sy_n == UC_LAST_BIT) begin
              sy_st <= UC_SY_IDLE;
            end
          end
        end
        UC_SY_RX: begin
          // sample on the rising shift clock edge
          if (sy_cnt == sy_half) begin
            sy_sh <= {rx_pin_in, sy_sh[7:1]}; // R5
          end
          if (sy_tick) begin
            sy_n <= sy_n + 3'h1;
            if (sy_n == UC_LAST_BIT) begin
              sy_st <= UC_SY_IDLE;
            end
          end
        end
        default: sy_st <= UC_SY_IDLE;
      endcase
    end
  end

  // pin drive and interrupt, all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link <= '{tx_pin: 1'b1, rx_pin_out: 1'b1, rx_pin_oe: 1'b0};
      irq <= 1'b0;
    end else begin
      link.tx_pin <= (uart_on && (mode == UC_MODE_SYNC)) ? sy_clk : tx_line; // R1 R4
      link.rx_pin_out <= sy_out;
      link.rx_pin_oe <= (sy_st == UC_SY_TX); // R4
      irq <= |({ti, ri} & irq_mask); // R2
    end
  end

endmodule
`default_nettype wire

// ### tb/uc_uart_checker.sv
// Purpose: port-level assertions for the uart channel
// Assumes: one clock, async active-low reset, first channel indexes
// Notes: shadows a few control fields from bus writes
`default_nettype none
module uc_uart_checker
  import uc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic rx_pin_in,
  input wire uc_link_s link,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic ap_v, ap_w; // data phase pending, and its direction
  logic [7:0] ap_i; // word index of that phase
  logic [1:0] mode_sh, fsel_sh, mask_sh; // shadowed fields
  logic mpr_sh; // shadowed rate or filter bit
  logic [15:0] d_sh; // shadowed divisor
  logic [16:0] low_cnt; // cycles the tx pin has been low
  wire hit = hsel && htrans[1] && hready && hsize == UC_HSIZE_WORD
    && haddr[31:10] == 22'h0 && haddr[1:0] == 2'b00;
  wire wr_now = ap_v && ap_w;
  wire rd_now = ap_v && !ap_w;
  // track the address phase into its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_v <= 1'b0;
      ap_w <= 1'b0;
      ap_i <= 8'h00;
    end else begin
      ap_v <= hit;
      ap_w <= hwrite;
      ap_i <= haddr[9:2];
    end
  end
  // copy control fields on register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {mode_sh, mpr_sh, fsel_sh, mask_sh, d_sh} <= '0;
    end else if (wr_now) begin
      case (ap_i)
        UC_IDX_P1_CTRL: {mode_sh, mpr_sh} <= hwdata[7:5];
        UC_IDX_P1_BAUD_LO: d_sh[7:0] <= hwdata[7:0];
        UC_IDX_P1_BAUD_HI: d_sh[15:8] <= hwdata[7:0];
        UC_IDX_FSEL: fsel_sh <= hwdata[1:0];
        UC_IDX_IRQ_MASK: mask_sh <= hwdata[1:0];
        default: ;
      endcase
    end
  end
  // length of the current low run on the tx pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_cnt <= '0;
    else low_cnt <= link.tx_pin ? 17'h0 : low_cnt + 17'h1;
  end
  a_ready_wait: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("transfer did not take exactly one wait state");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_rdata_change: assert property (!$stable(hrdata) |-> $past(rd_now))
    else $error("read data changed without a read");
  a_irq_hold: assert property ($fell(irq) |-> $past(wr_now) || $past(wr_now, 2)
    || $past(wr_now, 3))
    else $error("interrupt dropped without a register write");
  a_mask_off: assert property ((mask_sh == 2'b00) [*3] |-> !irq)
    else $error("interrupt high while fully masked");
  a_oe_sync: assert property (link.rx_pin_oe |-> mode_sh == UC_MODE_SYNC
    && fsel_sh == UC_FSEL_UART)
    else $error("rx pin driven outside synchronous mode");
  a_bit_len: assert property ($rose(link.tx_pin) && mode_sh[0] && fsel_sh == UC_FSEL_UART
    && d_sh != 16'h0 |-> low_cnt % d_sh == 17'h0)
    else $error("async low run not a whole number of bits");
  a_sync_half: assert property ($rose(link.tx_pin) && mode_sh == UC_MODE_SYNC
    && fsel_sh == UC_FSEL_UART |-> low_cnt == (mpr_sh ? 17'h2 : 17'h6))
    else $error("shift clock low phase has wrong length");
  c_irq: cover property ($rose(irq));
  c_sync_tx: cover property ($rose(link.rx_pin_oe));
  c_read: cover property (!$stable(hrdata));
endmodule
bind uc_uart uc_uart_checker chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_pin_in(rx_pin_in),
  .link(link), .irq(irq));
`default_nettype wire

// ### tb/uc_serial_peer.sv
// Purpose: behavioural far-side serial device
// Assumes: frames timed in system clocks
// Notes: async line idles high; sync mode only listens
`default_nettype none
module uc_serial_peer
  import uc_pkg::*;
(
  input wire logic hclk,
  input wire logic tx_pin,
  input wire logic rx_level,
  output logic drive
);
  timeunit 1ns;
  timeprecision 1ps;
  initial drive = 1'b1; // idle high
  // send one async frame, lsb first, stop level chosen by caller
  task automatic send(input logic [8:0] v, input int nb, input int d, input logic stp);
    @(posedge hclk);
    drive <= 1'b0; // start bit
    repeat (d) @(posedge hclk);
    for (int k = 0; k < nb; k++) begin
      drive <= v[k];
      repeat (d) @(posedge hclk);
    end
    drive <= stp;
    repeat (d) @(posedge hclk);
    drive <= 1'b1;
  endtask
  // capture an async frame at bit centres, stop bit on top
  task automatic get(input int nb, input int d, output logic [9:0] v);
    v = '0;
    @(negedge tx_pin);
    repeat (d / 2) @(posedge hclk);
    for (int k = 0; k <= nb; k++) begin
      repeat (d) @(posedge hclk);
      v[k] = tx_pin;
    end
  endtask
  // capture a shift-mode byte at rising shift clock, period in ns
  task automatic sget(output logic [7:0] v, output int per);
    time t0;
    t0 = 0;
    for (int k = 0; k < 8; k++) begin
      @(posedge tx_pin);
      v[k] = rx_level;
      if (k == 0) t0 = $time;
      if (k == 1) per = int'($time - t0);
    end
  endtask
endmodule
`default_nettype wire

// ### tb/usci_uart_channel_test.sv
// Purpose: self-checking bench for the uart channel
// Assumes: ahb-lite single word transfers, one clock
// Notes: peer model stands on the serial pins
`default_nettype none
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, e, a); end end
module usci_uart_channel_test
  import uc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] div_val = 16'h0011; // above 0x10
  localparam int dv = int'(div_val);
  localparam int clk_ns = 10;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = UC_HSIZE_WORD;
  logic hreadyout, hresp, irq, peer_drive;
  uc_link_s link;
  int n_mismatch = 0, comparisons = 0, cyc = 0, per;
  logic [9:0] v; // captured async frame
  logic [7:0] sv; // captured shift byte
  logic [7:0] regs [6] = '{UC_IDX_P1_CTRL, UC_IDX_P1_BAUD_LO, UC_IDX_P1_BAUD_HI,
    UC_IDX_P1_DATA, UC_IDX_IRQ_MASK, 8'h80};
  wire hready = hreadyout; // single slave
  wire rx_level = link.rx_pin_oe ? link.rx_pin_out : peer_drive; // shared rx wire
  uc_uart dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rx_pin_in(rx_level), .link(link), .irq(irq));
  uc_serial_peer peer (.hclk(hclk), .tx_pin(link.tx_pin), .rx_level(rx_level),
    .drive(peer_drive));
  // 100 MHz clock
  always #5 hclk = ~hclk;
  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // print counts and verdict
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    bus(1'b1, idx, wd, rd);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] e, input string nm);
    logic [31:0] rd;
    bus(1'b0, idx, 8'h00, rd);
    `CHK(nm, {24'h0, e}, rd)
  endtask
  // bounded wait for the interrupt line
  task automatic wait_irq();
    for (int k = 0; k < 600 && irq !== 1'b1; k++) @(posedge hclk);
    `CHK("irq", 1'b1, irq)
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (regs[i]) rc(regs[i], 8'h00, "reset value");
    wr(UC_IDX_P1_BAUD_LO, div_val[7:0]);
    wr(UC_IDX_P1_BAUD_HI, div_val[15:8]);
    rc(UC_IDX_P1_BAUD_LO, div_val[7:0], "baud_lo");
    wr(UC_IDX_P1_CTRL, 8'h40);
    wr(UC_IDX_P1_DATA, 8'h55);
    repeat (30) @(posedge hclk);
    `CHK("tx idle", 1'b1, link.tx_pin)
    rc(UC_IDX_P1_CTRL, 8'h40, "no uart");
    wr(UC_IDX_FSEL, 8'h03);
    wr(UC_IDX_IRQ_MASK, 8'h03);
    fork
      peer.get(8, dv, v);
      wr(UC_IDX_P1_DATA, 8'ha5);
    join
    `CHK("ten bit frame", 10'h1a5, v)
    wait_irq();
    rc(UC_IDX_P1_CTRL, 8'h42, "ti set");
    wr(UC_IDX_IRQ_MASK, 8'h01);
    @(posedge hclk);
    `CHK("masked irq", 1'b0, irq)
    wr(UC_IDX_IRQ_MASK, 8'h03);
    wr(UC_IDX_P1_CTRL, 8'h40);
    rc(UC_IDX_P1_CTRL, 8'h42, "write zero");
    wr(UC_IDX_P1_CTRL, 8'h42);
    rc(UC_IDX_P1_CTRL, 8'h40, "write one");
    peer.send(9'h03c, 8, dv, 1'b1);
    rc(UC_IDX_P1_CTRL, 8'h40, "no permit");
    wr(UC_IDX_P1_CTRL, 8'h50);
    peer.send(9'h03c, 8, dv, 1'b1);
    wait_irq();
    rc(UC_IDX_P1_CTRL, 8'h51, "ri set");
    rc(UC_IDX_P1_DATA, 8'h3c, "rx latch");
    wr(UC_IDX_P1_CTRL, 8'h51);
    peer.send(9'h0f0, 8, dv, 1'b0);
    rc(UC_IDX_P1_CTRL, 8'h50, "bad stop");
    rc(UC_IDX_P1_DATA, 8'h3c, "latch kept");
    wr(UC_IDX_P1_CTRL, 8'hf8);
    fork
      peer.get(9, dv, v);
      wr(UC_IDX_P1_DATA, 8'h5a);
    join
    `CHK("eleven bit frame", 10'h35a, v)
    wait_irq();
    wr(UC_IDX_P1_CTRL, 8'hfa);
    peer.send(9'h0c3, 9, dv, 1'b1);
    rc(UC_IDX_P1_CTRL, 8'hf8, "filtered");
    peer.send(9'h1c3, 9, dv, 1'b1);
    wait_irq();
    rc(UC_IDX_P1_CTRL, 8'hfd, "address frame");
    rc(UC_IDX_P1_DATA, 8'hc3, "rx latch");
    wr(UC_IDX_P1_CTRL, 8'hd9);
    peer.send(9'h07e, 9, dv, 1'b1);
    wait_irq();
    rc(UC_IDX_P1_CTRL, 8'hd9, "plain frame");
    rc(UC_IDX_P1_DATA, 8'h7e, "rx latch");
    for (int m = 0; m < 2; m++) begin
      wr(UC_IDX_P1_CTRL, {2'b00, m[0], 5'b00011});
      fork
        peer.sget(sv, per);
        wr(UC_IDX_P1_DATA, 8'h96);
      join
      `CHK("shift byte", 8'h96, sv)
      `CHK("shift period", (m ? 4 : 12) * clk_ns, per)
      wait_irq();
    end
    wr(UC_IDX_P1_CTRL, 8'h82);
    wr(UC_IDX_P1_DATA, 8'h33);
    repeat (30) @(posedge hclk);
    `CHK("reserved idle", 1'b1, link.tx_pin)
    rc(UC_IDX_P1_CTRL, 8'h80, "reserved mode");
    wrap_up();
  end
endmodule
`undef CHK
`default_nettype wire
